//--- rtl/crd_console.v
// Console register display control top level
`timescale 1ns/10ps
`include "crd_defines.vh"
module crd_console #(
	parameter WIDTH = 24
) (
	input  wire                      mclk,
	input  wire                      reset_n,
	input  wire                      clk_en,
	input  wire                      bit_strobe,
	input  wire                      t0,
	input  wire                      t10,
	input  wire                      t24,
	input  wire                      word_end,
	input  wire                      instr_end,
	input  wire [`CRD_PHASE_W-1:0]   phase,
	input  wire                      phase_bit_one,
	input  wire                      time_share_active,
	input  wire                      halt_instr,
	input  wire                      run_position,
	input  wire                      step_position,
	input  wire                      select_a_position,
	input  wire                      select_b_position,
	input  wire                      select_x_position,
	input  wire                      fill_switch,
	input  wire                      hold_switch,
	input  wire                      parity_override_switch,
	input  wire                      mem_parity_error,
	input  wire                      parity_clear,
	input  wire                      clear_switch,
	input  wire [WIDTH-1:0]          load_switches,
	input  wire [3:0]                breakpoint_sw,
	input  wire                      enable_switch,
	input  wire                      int_enable_ff,
	input  wire                      pending_request_line,
	input  wire                      int_entry_ack,
	input  wire                      pc_shift_request,
	input  wire                      cpu_c_shift,
	input  wire                      cpu_c_serial_in,
	input  wire                      mem_copy_request,
	input  wire [WIDTH-1:0]          mem_data,
	input  wire                      acc_serial_out,
	input  wire                      ext_serial_out,
	input  wire                      idx_serial_out,
	output reg                       run_flag,
	output reg                       halt_flag,
	output reg                       display_sel_hi,
	output reg                       display_sel_lo,
	output reg                       swap_active,
	output reg                       parity_error_flag,
	output reg                       int_entry,
	output wire                      pc_shift_enable,
	output wire                      opcode_load_enable,
	output wire                      force_nop,
	output wire                      acc_shift_enable,
	output wire                      ext_shift_enable,
	output wire                      idx_shift_enable,
	output wire                      swap_serial_out,
	output wire                      skip_condition,
	output wire [WIDTH-1:0]          instr_word
);
	reg  [1:0]                  swap_code;
	reg  [`CRD_SWAP_CNT_W-1:0]  swap_count;
	reg                         halt_by_parity;
	wire [1:0]                  disp_state;
	reg  [1:0]                  sel_target;
	wire                        swap_shift;
	wire                        swap_done;
	wire                        halted_idle;
	wire                        want_swap;
	wire                        run_set;
	wire                        run_clear;
	wire                        halt_set;
	wire                        halt_clear;
	wire                        parity_halt;
	wire                        c_shift_en;
	wire                        c_serial_in;
	wire                        mem_copy;
	reg                         home_serial;
	wire                        int_set;

	assign disp_state = {display_sel_hi, display_sel_lo};

	// Selector position to display code
	always @* begin
		if (select_a_position)
			sel_target = `CRD_DISP_ACC;
		else if (select_b_position)
			sel_target = `CRD_DISP_EXT;
		else if (select_x_position)
			sel_target = `CRD_DISP_IDX;
		else
			sel_target = `CRD_DISP_HOME;
	end

	// Halt flag sources
	assign parity_halt = parity_error_flag & word_end & ~parity_override_switch
		& ~time_share_active;
	assign halt_set = (halt_instr & t0)
		| (instr_end & t0 & run_flag & ~run_position)
		| parity_halt;
	// Cleared only back at idle, parity condition gone, or by fill
	assign halt_clear = fill_switch
		| (~run_flag & ~run_position & ~step_position
		& ~(halt_by_parity & ~parity_override_switch));

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			halt_flag      <= 1'b0;
			halt_by_parity <= 1'b0;
		end else if (clk_en) begin
			if (halt_set) begin
				halt_flag <= 1'b1;
				if (parity_halt)
					halt_by_parity <= 1'b1;
			end else if (halt_clear) begin
				halt_flag      <= 1'b0;
				halt_by_parity <= 1'b0;
			end
		end
	end

	// Parity error flag, held while override is at halt
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			parity_error_flag <= 1'b0;
		else if (clk_en) begin
			if (mem_parity_error)
				parity_error_flag <= 1'b1;
			else if (parity_clear & parity_override_switch)
				parity_error_flag <= 1'b0;
		end
	end

	// Run flag
	assign run_set = word_end & (disp_state == `CRD_DISP_HOME) & ~halt_flag
		& (run_position | step_position) & ~fill_switch;
	assign run_clear = word_end & instr_end & halt_flag;

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			run_flag <= 1'b0;
		else if (clk_en) begin
			if (run_clear)
				run_flag <= 1'b0;
			else if (run_set)
				run_flag <= 1'b1;
		end
	end

	// Swap request: selector change, return home, or home before step/run
	assign halted_idle = ~run_flag & ~halt_flag & ~time_share_active
		& ~fill_switch;
	assign want_swap = (sel_target != disp_state)
		| ((disp_state != `CRD_DISP_HOME) & (run_position | step_position));

	assign swap_shift = swap_active & bit_strobe
		& (swap_count != `CRD_SWAP_SHIFTS);
	assign swap_done = swap_active & t0 & phase_bit_one
		& (swap_count == `CRD_SWAP_SHIFTS);

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			swap_active <= 1'b0;
			swap_code   <= `CRD_DISP_HOME;
			swap_count  <= {`CRD_SWAP_CNT_W{1'b0}};
		end else if (clk_en) begin
			if (run_flag) begin
				swap_active <= 1'b0;
				swap_count  <= {`CRD_SWAP_CNT_W{1'b0}};
			end else if (swap_done) begin
				swap_active <= 1'b0;
				swap_count  <= {`CRD_SWAP_CNT_W{1'b0}};
			end else if (swap_active) begin
				if (swap_shift)
					swap_count <= swap_count + 1'b1;
			end else if (t24 & halted_idle & want_swap) begin
				swap_active <= 1'b1;
				swap_count  <= {`CRD_SWAP_CNT_W{1'b0}};
				if (disp_state != `CRD_DISP_HOME)
					swap_code <= disp_state;
				else
					swap_code <= sel_target;
			end
		end
	end

	// Display-select flags
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			display_sel_hi <= 1'b0;
			display_sel_lo <= 1'b0;
		end else if (clk_en) begin
			if (run_flag & (phase == `CRD_PHASE_FETCH)) begin
				display_sel_hi <= 1'b0;
				display_sel_lo <= 1'b0;
			end else if (swap_done) begin
				if (disp_state == `CRD_DISP_HOME) begin
					display_sel_hi <= swap_code[1];
					display_sel_lo <= swap_code[0];
				end else begin
					display_sel_hi <= 1'b0;
					display_sel_lo <= 1'b0;
				end
			end
		end
	end

	// Serial exchange loop between instruction and selected register
	always @* begin
		case (swap_code)
			`CRD_DISP_ACC: home_serial = acc_serial_out;
			`CRD_DISP_EXT: home_serial = ext_serial_out;
			`CRD_DISP_IDX: home_serial = idx_serial_out;
			default:       home_serial = 1'b0;
		endcase
	end

	assign acc_shift_enable = swap_shift & (swap_code == `CRD_DISP_ACC);
	assign ext_shift_enable = swap_shift & (swap_code == `CRD_DISP_EXT);
	assign idx_shift_enable = swap_shift & (swap_code == `CRD_DISP_IDX);

	// Instruction register shift sources; CPU shift blocked in the no-op phase
	assign c_shift_en = swap_shift | clear_switch
		| (cpu_c_shift & run_flag & (phase != `CRD_PHASE_NOP));
	assign c_serial_in = swap_shift ? home_serial
		: (clear_switch ? 1'b0 : cpu_c_serial_in);
	assign mem_copy = mem_copy_request & run_flag & ~swap_active;

	crd_instr_reg #(
		.WIDTH(WIDTH)
	) u_instr_reg (
		.mclk          (mclk),
		.reset_n       (reset_n),
		.clk_en        (clk_en),
		.shift_en      (c_shift_en),
		.serial_in     (c_serial_in),
		.mem_copy      (mem_copy),
		.mem_data      (mem_data),
		.load_switches (load_switches),
		.word          (instr_word),
		.msb_out       (swap_serial_out)
	);

	crd_breakpoint_skip #(
		.COUNT(4)
	) u_bkpt (
		.instr_word     (instr_word),
		.breakpoint_sw  (breakpoint_sw),
		.skip_condition (skip_condition)
	);

	// Program counter and opcode gating
	assign pc_shift_enable = pc_shift_request & run_flag & ~hold_switch
		& ~time_share_active;
	assign opcode_load_enable = run_flag;
	assign force_nop = ~run_flag;

	// Interrupt entry, forced enable by switch
	assign int_set = t10 & instr_end & pending_request_line
		& (int_enable_ff | enable_switch);

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			int_entry <= 1'b0;
		else if (clk_en) begin
			if (int_set)
				int_entry <= 1'b1;
			else if (int_entry_ack)
				int_entry <= 1'b0;
		end
	end
endmodule

//--- rtl/crd_defines.vh
// Constants for the console register display control
// Behaviour
// - Program counter shift enable withheld while run flag is reset.
// - Memory-to-instruction-register copy blocked at instruction end while not running.
// - Halted machine repeats a no-op in phase 5; no CPU shift of instruction register there, swap and clear shifts still run.
// - Register display by swap only while run and halt flags both reset.
// - Two display-select flags encode which register sits in instruction register.
// - Both display-select flags clear during phase 0 while running.
// - Halted, no time-share, selector differs from display state: swap flag set at T24.
// - Swap flag lasts one word cycle, cleared at T0 under phase condition.
// - During swap, instruction register and selected register shift together in a loop.
// - At swap-ending T0, display flags take moved register code or clear.
// - Selector back at instruction position with flag set: swap home at T24.
// - Flag set when step or run chosen: swap registers home first.
// - Run flag set at word end only with flags clear, not halted, run/step chosen.
// - While running the selector is ignored; swap stays reset, display flags change only by the phase 0 clear.
// - After halt instruction or parity halt, no swap until idle, and after parity halt also override continue.
// - Step held keeps halt flag set; on release halt clears, swap may follow.
// - Hold switch disables program counter shift enable.
// - Override continue: no parity halt; override halt: halt and keep parity flag.
// - Clear switch shifts instruction register with zero fill until all zero.
// - Load switches set instruction register bits without shift enable.
// - Four breakpoint switches selected by address bits 15 to 18 drive skip condition.
// - Enable switch forces interrupt enable; entry set at T10 of instruction end.
// - Halt from halt instruction stays set until control switch returns to idle or fill switch is set.
// - Fill switch clears halt but blocks run and swap flags until released.
`ifndef CRD_DEFINES_VH
`define CRD_DEFINES_VH

`define CRD_WORD_BITS     24
`define CRD_PHASE_W       3
`define CRD_PHASE_FETCH   3'h0
`define CRD_PHASE_NOP     3'h5
`define CRD_DISP_HOME     2'h0
`define CRD_DISP_EXT      2'h1
`define CRD_DISP_ACC      2'h2
`define CRD_DISP_IDX      2'h3
`define CRD_SKIP_ADDR_A   10
`define CRD_SKIP_ADDR_B   11
`define CRD_SKIP_SEL_LO   15
`define CRD_BKPT_COUNT    4
`define CRD_SWAP_CNT_W    5
`define CRD_SWAP_SHIFTS   5'h18
`define CRD_RESET_WORD    24'h00_0000

`endif

//--- rtl/crd_instr_reg.v
// Instruction register with serial shift, clear, load switches and memory copy
`timescale 1ns/10ps
module crd_instr_reg #(
	parameter WIDTH = 24
) (
	input  wire             mclk,
	input  wire             reset_n,
	input  wire             clk_en,
	input  wire             shift_en,
	input  wire             serial_in,
	input  wire             mem_copy,
	input  wire [WIDTH-1:0] mem_data,
	input  wire [WIDTH-1:0] load_switches,
	output reg  [WIDTH-1:0] word,
	output wire             msb_out
);
	reg [WIDTH-1:0] next_word;

	assign msb_out = word[WIDTH-1];

	always @* begin
		next_word = word;
		if (mem_copy)
			next_word = mem_data;
		else if (shift_en)
			next_word = {word[WIDTH-2:0], serial_in};
		next_word = next_word | load_switches;
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			word <= {WIDTH{1'b0}};
		else if (clk_en)
			word <= next_word;
	end
endmodule

//--- rtl/crd_breakpoint_skip.v
// Breakpoint switch selection for the skip-on-signal test
`timescale 1ns/10ps
`include "crd_defines.vh"
module crd_breakpoint_skip #(
	parameter COUNT = 4
) (
	input  wire [`CRD_WORD_BITS-1:0] instr_word,
	input  wire [COUNT-1:0]          breakpoint_sw,
	output wire                      skip_condition
);
	wire [COUNT-1:0] hit;
	genvar i;

	generate
		for (i = 0; i < COUNT; i = i + 1) begin : g_bkpt
			assign hit[i] = instr_word[`CRD_SKIP_SEL_LO + i] & breakpoint_sw[i];
		end
	endgenerate

	assign skip_condition = instr_word[`CRD_SKIP_ADDR_A] & ~instr_word[`CRD_SKIP_ADDR_B]
		& (|hit);
endmodule

//--- verif/crd_partner_model.sv
// Pulse timing and serial A, B and X registers beside the console
`timescale 1ns/10ps
module crd_partner #(
	parameter [23:0] ACC_INIT = 24'h00_0000,
	parameter [23:0] EXT_INIT = 24'h00_0000,
	parameter [23:0] IDX_INIT = 24'h00_0000
) (
	input  wire mclk, reset_n, clk_en, swap_serial_out,
	input  wire acc_shift_enable, ext_shift_enable, idx_shift_enable,
	output wire bit_strobe, t0, t10, t24, word_end,
	output wire acc_serial_out, ext_serial_out, idx_serial_out
);
	reg [4:0]  pt;
	reg [23:0] acc, ext, idx;
	assign bit_strobe = clk_en;
	assign t0 = bit_strobe && pt == 5'h00;
	assign t10 = bit_strobe && pt == 5'h0a;
	assign t24 = bit_strobe && pt == 5'h18;
	// Word end lands just before T24 so a run start precedes any new swap
	assign word_end = bit_strobe && pt == 5'h17;
	assign acc_serial_out = acc[23];
	assign ext_serial_out = ext[23];
	assign idx_serial_out = idx[23];
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pt <= 5'h00;
			acc <= ACC_INIT;
			ext <= EXT_INIT;
			idx <= IDX_INIT;
		end else if (clk_en) begin
			pt <= (pt == 5'h18) ? 5'h00 : pt + 5'h01;
			if (acc_shift_enable) acc <= {acc[22:0], swap_serial_out};
			if (ext_shift_enable) ext <= {ext[22:0], swap_serial_out};
			if (idx_shift_enable) idx <= {idx[22:0], swap_serial_out};
		end
	end
endmodule

//--- verif/crd_console_monitor.sv
// Port checker for the console register display control
`timescale 1ns/10ps
`include "crd_defines.vh"
module crd_monitor #(
	parameter WIDTH = 24
) (
	input wire                    mclk, reset_n, t0, t10, t24, word_end,
	input wire [`CRD_PHASE_W-1:0] phase,
	input wire                    time_share_active, run_position, step_position, fill_switch,
	input wire                    hold_switch, parity_override_switch, enable_switch,
	input wire                    int_enable_ff, pending_request_line, run_flag, halt_flag,
	input wire                    display_sel_hi, display_sel_lo, swap_active, parity_error_flag,
	input wire                    int_entry, pc_shift_enable, opcode_load_enable, force_nop,
	input wire                    acc_shift_enable, ext_shift_enable, idx_shift_enable,
	input wire                    swap_serial_out,
	input wire [WIDTH-1:0]        instr_word
);
	wire      shift_any = acc_shift_enable | ext_shift_enable | idx_shift_enable;
	reg [5:0] shift_cnt;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Shifts seen within the current swap
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			shift_cnt <= 6'h00;
		else
			shift_cnt <= swap_active ? shift_cnt + {5'h00, shift_any} : 6'h00;
	end
	a_pc_gate: assert property (pc_shift_enable |-> run_flag && !hold_switch)
		else $error("pc shift enabled while halted or held");
	a_nop_gate: assert property (force_nop != run_flag && opcode_load_enable == run_flag)
		else $error("opcode load or nop not tied to run flag");
	a_swap_start: assert property (!swap_active && !(t24 && !run_flag && !halt_flag
		&& !time_share_active && !fill_switch) |=> !swap_active)
		else $error("swap started outside a halted T24");
	a_swap_end: assert property ($fell(swap_active) |-> $past(t0))
		else $error("swap ended away from T0");
	a_shift_total: assert property ($fell(swap_active) |-> shift_cnt == 6'h18)
		else $error("swap did not shift 24 bits");
	a_shift_route: assert property (shift_any |-> swap_active && $onehot({acc_shift_enable,
		ext_shift_enable, idx_shift_enable}) && swap_serial_out == instr_word[WIDTH-1])
		else $error("register shift outside swap or not single");
	a_disp_clear: assert property (run_flag && phase == `CRD_PHASE_FETCH |=>
		!display_sel_hi && !display_sel_lo)
		else $error("display flags not cleared in fetch phase");
	a_disp_hold: assert property (!swap_active && !(run_flag && phase == `CRD_PHASE_FETCH)
		|=> $stable({display_sel_hi, display_sel_lo}))
		else $error("display flags moved without a swap");
	a_run_gate: assert property ($rose(run_flag) |-> $past(word_end) && !$past(halt_flag)
		&& !$past(display_sel_hi) && !$past(display_sel_lo)
		&& ($past(run_position) || $past(step_position)))
		else $error("run flag set without its conditions");
	a_halt_keep: assert property (halt_flag && (run_position || step_position)
		&& !fill_switch |=> halt_flag)
		else $error("halt flag dropped with control switch active");
	a_int_entry: assert property ($rose(int_entry) |-> $past(t10) && $past(pending_request_line)
		&& ($past(int_enable_ff) || $past(enable_switch)))
		else $error("interrupt entry without enabled request at T10");
	a_parity_keep: assert property (parity_error_flag && !parity_override_switch
		|=> parity_error_flag)
		else $error("parity flag cleared while override at halt");
	c_swap: cover property ($rose(swap_active));
	c_run: cover property ($rose(run_flag));
	c_int: cover property ($rose(int_entry));
endmodule

//--- verif/test_console_register_display_control.sv
// Self-checking bench for the console register display control
`timescale 1ns/10ps
`include "crd_defines.vh"
module test_console_register_display_control;
	localparam [23:0] ACC_V = 24'h12_3456;
	localparam [23:0] EXT_V = 24'h65_4321;
	localparam [23:0] IDX_V = 24'hc3_5a0f;
	reg         mclk = 0, reset_n = 0, clk_en = 1, instr_end = 0, phase_bit_one = 1;
	reg         time_share_active = 0, halt_instr = 0, run_position = 0, step_position = 0;
	reg         select_a_position = 0, select_b_position = 0, select_x_position = 0;
	reg         fill_switch = 0, hold_switch = 0, parity_override_switch = 1, parity_clear = 0;
	reg         mem_parity_error = 0, clear_switch = 0, enable_switch = 0, int_enable_ff = 0;
	reg         pending_request_line = 0, int_entry_ack = 0, pc_shift_request = 0;
	reg         cpu_c_shift = 0, cpu_c_serial_in = 0, mem_copy_request = 0;
	reg [2:0]   phase = `CRD_PHASE_NOP;
	reg [3:0]   breakpoint_sw = 0;
	reg [23:0]  load_switches = 0, mem_data = 0, word;
	reg [57:0]  rows [0:4];
	integer     miscompares = 0, checks_done = 0, r, i;
	wire        bit_strobe, t0, t10, t24, word_end, acc_serial_out, ext_serial_out;
	wire        idx_serial_out, run_flag, halt_flag, display_sel_hi, display_sel_lo, swap_active;
	wire        parity_error_flag, int_entry, pc_shift_enable, opcode_load_enable, force_nop;
	wire        acc_shift_enable, ext_shift_enable, idx_shift_enable, swap_serial_out;
	wire        skip_condition;
	wire [23:0] instr_word;
	crd_console dut (.*);
	crd_partner #(.ACC_INIT(ACC_V), .EXT_INIT(EXT_V), .IDX_INIT(IDX_V)) partner (.*);
	task cyc(input integer n);
		repeat (n) @(negedge mclk);
	endtask
	task cmp(input [23:0] got, input [23:0] exp, input [8*12-1:0] msg);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				miscompares = miscompares + 1;
				$display("[FAIL] %0t %0s", $time, msg);
			end
		end
	endtask
	task swap_wait;
		begin
			for (i = 0; i < 90 && swap_active !== 1'b1; i = i + 1)
				cyc(1);
			cmp(swap_active, 1, "swap start");
			for (i = 0; i < 40 && swap_active !== 1'b0; i = i + 1)
				cyc(1);
			cmp(swap_active, 0, "swap end");
			cyc(1);
		end
	endtask
	task load_c(input [23:0] w);
		begin
			clear_switch = 1;
			cyc(26);
			cmp(instr_word, 0, "clear");
			clear_switch = 0;
			load_switches = w;
			cyc(1);
			load_switches = 0;
			cyc(1);
			cmp(instr_word, w, "load");
		end
	endtask
	task end_of_test;
		begin
			$display("checks %0d miscompares %0d", checks_done, miscompares);
			if (miscompares == 0 && checks_done > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	initial begin
		forever #2.5 mclk = ~mclk;
	end
	initial begin
		#20000;
		miscompares = miscompares + 1;
		end_of_test;
	end
	initial begin
		// Row: word, breakpoints, skip, selector a b x, display code, shown value
		rows[0] = {24'h00_85a5, 4'h1, 1'b1, 3'b100, `CRD_DISP_ACC, ACC_V};
		rows[1] = {24'h01_0400, 4'h2, 1'b1, 3'b010, `CRD_DISP_EXT, EXT_V};
		rows[2] = {24'h02_0c00, 4'h4, 1'b0, 3'b001, `CRD_DISP_IDX, IDX_V};
		rows[3] = {24'h04_0400, 4'h8, 1'b1, 3'b100, `CRD_DISP_ACC, ACC_V};
		rows[4] = {24'h04_8000, 4'hf, 1'b0, 3'b010, `CRD_DISP_EXT, EXT_V};
		cyc(2);
		reset_n = 1;
		cyc(1);
		cmp({run_flag, halt_flag, display_sel_hi, display_sel_lo, swap_active,
			parity_error_flag, int_entry}, 0, "reset");
		for (r = 0; r < 5; r = r + 1) begin
			{word, breakpoint_sw} = rows[r][57:30];
			load_c(word);
			cmp(skip_condition, rows[r][29], "skip");
			{select_a_position, select_b_position, select_x_position} = rows[r][28:26];
			swap_wait;
			cmp({display_sel_hi, display_sel_lo}, rows[r][25:24], "code");
			cmp(instr_word, rows[r][23:0], "shown");
			{select_a_position, select_b_position, select_x_position} = 3'b000;
			swap_wait;
			cmp({display_sel_hi, display_sel_lo}, 0, "home");
			cmp(instr_word, word, "back");
		end
		{time_share_active, select_a_position} = 2'b11;
		{mem_copy_request, cpu_c_shift, cpu_c_serial_in, pc_shift_request} = 4'hf;
		mem_data = 24'hff_ffff;
		cyc(40);
		cmp(swap_active, 0, "ts swap");
		cmp(instr_word, word, "frozen");
		cmp({pc_shift_enable, force_nop}, 1, "halt gate");
		{time_share_active, mem_copy_request, cpu_c_shift, cpu_c_serial_in} = 4'h0;
		swap_wait;
		run_position = 1;
		swap_wait;
		for (i = 0; i < 60 && run_flag !== 1'b1; i = i + 1)
			cyc(1);
		cmp({run_flag, display_sel_hi, display_sel_lo}, 3'b100, "run home");
		phase = `CRD_PHASE_FETCH;
		hold_switch = 1;
		cyc(1);
		cmp(pc_shift_enable, 0, "hold");
		hold_switch = 0;
		cyc(30);
		cmp({pc_shift_enable, opcode_load_enable, swap_active}, 3'b110, "running");
		{enable_switch, pending_request_line, instr_end} = 3'b111;
		cyc(30);
		cmp(int_entry, 1, "int entry");
		{pending_request_line, int_entry_ack} = 2'b01;
		cyc(1);
		int_entry_ack = 0;
		cyc(1);
		cmp(int_entry, 0, "int ack");
		halt_instr = 1;
		cyc(30);
		{halt_instr, phase} = {1'b0, `CRD_PHASE_NOP};
		cyc(60);
		cmp({run_flag, halt_flag, swap_active}, 3'b010, "halt kept");
		fill_switch = 1;
		cyc(60);
		cmp({halt_flag, run_flag, swap_active}, 0, "fill");
		{fill_switch, parity_override_switch, mem_parity_error} = 3'b001;
		cyc(1);
		{mem_parity_error, parity_clear} = 2'b01;
		cyc(60);
		cmp({parity_error_flag, halt_flag}, 2'b11, "parity");
		end_of_test;
	end
endmodule
bind crd_console crd_monitor #(.WIDTH(WIDTH)) monitor (.*);
